// *** logic/nrs_map.svh ***
// register offsets, field positions and reset values of the rs ecc status block
`ifndef NRS_MAP_SVH
`define NRS_MAP_SVH

// byte offsets on the register bus
`define NRS_OFF_STATUS 4'h0
`define NRS_OFF_ENABLE 4'h4
`define NRS_OFF_CTRL 4'h8

// status register fields
`define NRS_CNT_HI 31
`define NRS_CNT_LO 29
`define NRS_FLAG_HI 4
`define NRS_ST_PAD 4
`define NRS_ST_DEC 3
`define NRS_ST_ENC 2
`define NRS_ST_UNF 1
`define NRS_ST_FLT 0

// enable register fields, bit 3 is reserved
`define NRS_EN_PAD 4
`define NRS_EN_CODEC 2
`define NRS_EN_UNF 1
`define NRS_EN_FLT 0
`define NRS_EN_MASK 5'h17

// control register fields
`define NRS_CTL_ON 0
`define NRS_CTL_CLR 1

// reset values
`define NRS_RST_FLAGS 5'h00
`define NRS_RST_COUNT 3'h0
`define NRS_RST_ENABLE 5'h00
`define NRS_RST_RDATA 32'h0000_0000

// code geometry of the rs codec
`define NRS_SYM_BITS 9
`define NRS_CW_SYMS 511
`define NRS_MSG_SYMS 503
`define NRS_MAX_FIX ((`NRS_CW_SYMS - `NRS_MSG_SYMS) / 2)

`endif

// *** logic/nrs_pkg.sv ***
// types shared by the rs ecc status block
package nrs_pkg;

  // event pulses and error count from the codec, flag order matches status bits 4..0
  typedef struct packed {
    logic pad;
    logic dec;
    logic enc;
    logic unfix;
    logic fault;
    logic [2:0] count;
  } nrs_evt_t;

  typedef logic [4:0] nrs_flags_t;

  // bus answer states, gray along idle -> answer -> idle
  typedef enum logic [1:0] {
    NRS_BUS_IDLE = 2'b00,
    NRS_BUS_ANSWER = 2'b01
  } nrs_bus_t;

endpackage

// *** logic/nrs_flag_bank.sv ***
// sticky status flags, hardware set beats software clear
`timescale 1ns/1ps
`include "nrs_map.svh"

module nrs_flag_bank (
  input logic clk,
  input logic srst,
  input nrs_pkg::nrs_flags_t set,
  input nrs_pkg::nrs_flags_t clr,
  output nrs_pkg::nrs_flags_t flags
);
  import nrs_pkg::*;

  nrs_flags_t flags_q;

  // clear first, then or in the set so a coinciding event is never lost
  always_ff @(posedge clk) begin
    if (srst) begin
      flags_q <= `NRS_RST_FLAGS;
    end else begin
      flags_q <= (flags_q & ~clr) | set;
    end
  end

  assign flags = flags_q;

  chk_set_wins_clear: assert property (@(posedge clk) disable iff (srst)
    (set & clr) != 5'h00 |=> (flags_q & $past(set & clr)) == $past(set & clr))
    else $error("coinciding set and clear dropped a flag");

  chk_clear_drops: assert property (@(posedge clk) disable iff (srst)
    (clr & ~set) != 5'h00 |=> (flags_q & $past(clr & ~set)) == 5'h00)
    else $error("software clear did not drop the flag");

endmodule

// *** logic/nrs_irq_top.sv ***
// avalon register front end, error count and interrupt gate of the rs ecc unit
`timescale 1ns/1ps
`include "nrs_map.svh"


module nrs_irq_top (
  input logic clk,
  input logic srst,
  input logic [3:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [31:0] avs_writedata,
  input logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input nrs_pkg::nrs_evt_t codec_evt,
  output logic irq,
  output logic ecc_on,
  output logic ecc_clear
);
  import nrs_pkg::*;

  // expands byte enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // maps the enable bits onto the five flags, one enable serves both codec flags
  function automatic nrs_flags_t gate_vec(input logic [4:0] en);
    gate_vec = {en[`NRS_EN_PAD], en[`NRS_EN_CODEC], en[`NRS_EN_CODEC],
                en[`NRS_EN_UNF], en[`NRS_EN_FLT]};
  endfunction

  // count as reported: zero when unfixable or beyond the code's reach
  function automatic logic [2:0] fix_count(input nrs_evt_t e);
    if (e.unfix) begin
      fix_count = 3'h0;
    end else if (e.count > 3'(`NRS_MAX_FIX)) begin
      fix_count = 3'h0;
    end else begin
      fix_count = e.count;
    end
  endfunction

  nrs_bus_t bus_q;
  nrs_bus_t bus_d;
  logic wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [4:0] en_q;
  logic [2:0] count_q;
  logic on_q;
  logic clr_q;
  logic irq_q;
  nrs_flags_t flags;
  nrs_flags_t flag_set;
  nrs_flags_t flag_clr;
  logic [31:0] wmask;
  logic commit;
  logic wr_status;
  logic wr_enable;
  logic wr_ctrl;
  logic clr_req;

  // a request is answered one cycle after it is seen; writes land on the
  // edge where waitrequest is low, so the master's view and ours agree
  assign commit = (bus_q == NRS_BUS_ANSWER);
  assign wmask = lane_mask(avs_byteenable);
  assign wr_status = commit && avs_write && (avs_address == `NRS_OFF_STATUS);
  assign wr_enable = commit && avs_write && (avs_address == `NRS_OFF_ENABLE);
  assign wr_ctrl = commit && avs_write && (avs_address == `NRS_OFF_CTRL);
  assign clr_req = wr_ctrl && wmask[`NRS_CTL_CLR] && avs_writedata[`NRS_CTL_CLR];

  // bus state: idle takes a request, answer releases it
  always_comb begin
    bus_d = bus_q;
    case (bus_q)
      NRS_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          bus_d = NRS_BUS_ANSWER;
        end
      end
      NRS_BUS_ANSWER: begin
        bus_d = NRS_BUS_IDLE;
      end
      default: begin
        bus_d = NRS_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      bus_q <= NRS_BUS_IDLE;
    end else begin
      bus_q <= bus_d;
    end
  end

  // waitrequest stays high except in the single answer cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= (bus_d != NRS_BUS_ANSWER);
    end
  end

  // read mux; unmapped and unaligned addresses read zero
  always_comb begin
    rdata_d = `NRS_RST_RDATA;
    if (avs_address == `NRS_OFF_STATUS) begin
      rdata_d[`NRS_CNT_HI:`NRS_CNT_LO] = count_q;
      rdata_d[`NRS_FLAG_HI:0] = flags;
    end else if (avs_address == `NRS_OFF_ENABLE) begin
      rdata_d[4:0] = en_q & `NRS_EN_MASK;
    end else if (avs_address == `NRS_OFF_CTRL) begin
      rdata_d[`NRS_CTL_ON] = on_q; // clear is a pulse and reads zero
    end
  end

  // read data is sampled when the request is first seen and held afterwards
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= `NRS_RST_RDATA;
    end else if (bus_q == NRS_BUS_IDLE && avs_read) begin
      rdata_q <= rdata_d;
    end
  end

  // codec events map straight onto the flag vector
  assign flag_set = {codec_evt.pad, codec_evt.dec, codec_evt.enc,
                     codec_evt.unfix, codec_evt.fault};

  // only bits in enabled bytes that are written 0 clear; count lane is ignored
  assign flag_clr = wr_status ? (wmask[4:0] & ~avs_writedata[4:0]) : 5'h00;

  nrs_flag_bank u_flags (
    .clk(clk),
    .srst(srst),
    .set(flag_set),
    .clr(flag_clr),
    .flags(flags)
  );

  // enable register; reserved bit 3 and the upper bits are never stored
  always_ff @(posedge clk) begin
    if (srst) begin
      en_q <= `NRS_RST_ENABLE;
    end else if (wr_enable) begin
      en_q <= ((en_q & ~wmask[4:0]) | (avs_writedata[4:0] & wmask[4:0])) & `NRS_EN_MASK;
    end
  end

  // error count: captured at decode done; a fresh result beats a clear
  // in the same cycle so that block's outcome stays visible
  always_ff @(posedge clk) begin
    if (srst) begin
      count_q <= `NRS_RST_COUNT;
    end else if (codec_evt.dec) begin
      count_q <= fix_count(codec_evt);
    end else if (clr_req) begin
      count_q <= `NRS_RST_COUNT;
    end
  end

  // control: ecc on is a level, ecc clear a one-cycle pulse to the codec;
  // software is expected to raise both at once before each block
  always_ff @(posedge clk) begin
    if (srst) begin
      on_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      if (wr_ctrl && wmask[`NRS_CTL_ON]) begin
        on_q <= avs_writedata[`NRS_CTL_ON];
      end
      clr_q <= clr_req;
    end
  end

  // interrupt from registered flags; one extra cycle of latency keeps it glitch free
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags & gate_vec(en_q));
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign irq = irq_q;
  assign ecc_on = on_q;
  assign ecc_clear = clr_q;

  default clocking cb @(posedge clk);
  endclocking

  default disable iff (srst);

  // a read that is seen idle and then answered
  sequence s_read_seen;
    bus_q == NRS_BUS_IDLE && avs_read;
  endsequence

  sequence s_answer;
    !avs_waitrequest && bus_q == NRS_BUS_ANSWER;
  endsequence

  // a decode done that comes with a valid count
  sequence s_good_decode;
    codec_evt.dec && !codec_evt.unfix && codec_evt.count != 3'h0 && codec_evt.count <= 3'h4;
  endsequence

  chk_count_field: assert property (
    s_read_seen ##1 s_answer |-> avs_readdata[31:29] == $past(count_q) ||
    $past(avs_address) != `NRS_OFF_STATUS)
    else $error("status read did not return the error count");

  chk_count_range: assert property (
    count_q <= 3'h4)
    else $error("error count above four");

  chk_count_unfix: assert property (
    codec_evt.dec && codec_evt.unfix |=> count_q == 3'h0)
    else $error("unfixable block left a nonzero count");

  chk_count_take: assert property (
    s_good_decode |=> count_q == $past(codec_evt.count))
    else $error("decode count not captured");

  chk_count_clear: assert property (
    clr_req && !codec_evt.dec |=> count_q == 3'h0 ##0 ecc_clear ##1 !ecc_clear)
    else $error("ecc clear did not zero the count or pulse once");

  chk_count_nowrite: assert property (
    wr_status && !codec_evt.dec && !clr_req |=> $stable(count_q))
    else $error("status write changed the error count");

  chk_status_clear: assert property (
    wr_status && avs_byteenable[0] && !avs_writedata[0] && !codec_evt.fault |=> !flags[0])
    else $error("write of zero did not clear the fault flag");

  chk_status_keep: assert property (
    wr_status && avs_writedata[4:0] == 5'h1f && flag_set == 5'h00 |=> flags == $past(flags))
    else $error("write of one changed a flag");

  chk_rsvd_read: assert property (
    s_answer ##0 avs_read |-> avs_readdata[28:5] == 24'h000000)
    else $error("reserved status bits read nonzero");

  chk_rsvd_enable: assert property (
    en_q[3] == 1'b0)
    else $error("reserved enable bit stored");

  chk_pad_set: assert property (
    codec_evt.pad |=> flags[`NRS_ST_PAD])
    else $error("padding done not flagged");

  chk_dec_set: assert property (
    codec_evt.dec |=> flags[`NRS_ST_DEC])
    else $error("decode done not flagged");

  chk_enc_set: assert property (
    codec_evt.enc |=> flags[`NRS_ST_ENC])
    else $error("encode done not flagged");

  chk_unf_set: assert property (
    codec_evt.unfix |=> flags[`NRS_ST_UNF])
    else $error("unfixable not flagged");

  chk_flt_set: assert property (
    codec_evt.fault |=> flags[`NRS_ST_FLT])
    else $error("fault not flagged");

  chk_enable_write: assert property (
    wr_enable && avs_byteenable[0] |=> en_q == ($past(avs_writedata[4:0]) & `NRS_EN_MASK))
    else $error("enable register did not take the write");

  chk_irq_pad: assert property (
    flags[`NRS_ST_PAD] && en_q[`NRS_EN_PAD] |=> irq)
    else $error("padding interrupt not raised");

  chk_irq_codec: assert property (
    (flags[`NRS_ST_DEC] || flags[`NRS_ST_ENC]) && en_q[`NRS_EN_CODEC] |=> irq)
    else $error("codec done interrupt not raised");

  chk_irq_unf: assert property (
    flags[`NRS_ST_UNF] && en_q[`NRS_EN_UNF] |=> irq)
    else $error("unfixable interrupt not raised");

  chk_irq_flt: assert property (
    flags[`NRS_ST_FLT] && en_q[`NRS_EN_FLT] |=> irq)
    else $error("fault interrupt not raised");

  chk_irq_quiet: assert property (
    (flags & gate_vec(en_q)) == 5'h00 |=> !irq)
    else $error("interrupt raised with no enabled flag");

  chk_bus_answer: assert property (
    s_read_seen |=> s_answer ##1 avs_waitrequest)
    else $error("read not answered in one cycle");

  // writes follow the same single-cycle answer, and state that nobody
  // touches must hold, so a stray enable or clear shows up at once
  chk_write_answer: assert property (
    avs_write && bus_q == NRS_BUS_IDLE |=> s_answer ##1 avs_waitrequest)
    else $error("write not answered in one cycle");

  chk_ctrl_on: assert property (
    wr_ctrl && wmask[`NRS_CTL_ON] |=> ecc_on == $past(avs_writedata[`NRS_CTL_ON]))
    else $error("ecc on bit did not take the write");

  chk_clear_once: assert property (
    ecc_clear |=> !ecc_clear)
    else $error("ecc clear pulse lasted more than one cycle");

  chk_enable_hold: assert property (
    !wr_enable |=> $stable(en_q))
    else $error("enable register changed without a write");

  chk_flags_hold: assert property (
    flag_set == 5'h00 && flag_clr == 5'h00 |=> $stable(flags))
    else $error("status flag changed with no event or clear");

endmodule

// *** verif/nrs_irq_top_tb.sv ***
// self-checking bench for the rs ecc status and interrupt enable block
`timescale 1ns/1ps
`include "nrs_map.svh"

module nrs_irq_top_tb;
  import nrs_pkg::*;

  logic clk;
  logic srst;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  nrs_evt_t codec_evt;
  logic irq;
  logic ecc_on;
  logic ecc_clear;
  int failures;
  int checks;
  logic [31:0] rd;

  nrs_irq_top uut (
    .clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .codec_evt(codec_evt), .irq(irq), .ecc_on(ecc_on),
    .ecc_clear(ecc_clear)
  );

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // one bus access; the first edge keeps the previous release and this raise apart
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= addr;
    avs_writedata <= data;
    avs_read <= ~wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    chk1(n == 2, 1'b1, "bus answer latency");
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] addr, input logic [31:0] data);
    logic [31:0] dummy;
    bus(1'b1, addr, data, dummy);
  endtask

  // one-cycle codec pulse
  task automatic pulse(input logic [7:0] ev);
    @(posedge clk);
    codec_evt <= nrs_evt_t'(ev);
    @(posedge clk);
    codec_evt <= nrs_evt_t'(8'h00);
  endtask

  // enable bit that gates flag i
  function automatic int gate_of(input int i);
    return (i == 4) ? 4 : ((i == 3) ? 2 : i);
  endfunction

  task automatic t_reset();
    bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
    chk32(rd, 32'h0000_0000, "status reset");
    bus(1'b0, `NRS_OFF_ENABLE, 32'h0, rd);
    chk32(rd, 32'h0000_0000, "enable reset");
    chk1(irq, 1'b0, "irq reset");
    wr(`NRS_OFF_ENABLE, 32'hffff_ffff);
    bus(1'b0, `NRS_OFF_ENABLE, 32'h0, rd);
    chk32(rd, 32'h0000_0017, "enable reserved");
    $display("test reset done");
  endtask

  // each source sets its own bit, irq follows, a zero write clears it
  task automatic t_flags();
    for (int i = 0; i < 5; i++) begin
      pulse(8'((1 << (i + 3)) | ((i == 3) ? 3 : 0)));
      bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
      chk32(rd, {(i >= 3) ? 3'h3 : 3'h0, 24'h0, 5'(1 << i)}, "flag set");
      chk1(irq, 1'b1, "irq on flag");
      wr(`NRS_OFF_STATUS, 32'h0000_0000);
      bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
      chk32(rd, {(i >= 3) ? 3'h3 : 3'h0, 29'h0}, "flag clear");
      repeat (2) @(posedge clk);
      chk1(irq, 1'b0, "irq after clear");
    end
    $display("test flags done");
  endtask

  // one enable bit at a time against every source
  task automatic t_gate();
    int en[4] = '{0, 1, 2, 4};
    for (int e = 0; e < 4; e++) begin
      wr(`NRS_OFF_ENABLE, 32'(1 << en[e]));
      for (int i = 0; i < 5; i++) begin
        pulse(8'(1 << (i + 3)));
        repeat (2) @(posedge clk);
        chk1(irq, gate_of(i) == en[e], "irq gate");
        wr(`NRS_OFF_STATUS, 32'h0000_0000);
      end
    end
    $display("test gate done");
  endtask

  task automatic t_count();
    pulse({5'b01000, 3'h5});
    bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
    chk32(rd, 32'h0000_0008, "count over four");
    pulse({5'b01010, 3'h2});
    bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
    chk32(rd, 32'h0000_000a, "count with unfixable");
    pulse({5'b01000, 3'h4});
    wr(`NRS_OFF_STATUS, 32'h3fff_ffff);
    bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
    chk32(rd, 32'h8000_000a, "write ones keeps");
    wr(`NRS_OFF_CTRL, 32'h0000_0003);
    @(posedge clk);
    chk1(ecc_on, 1'b1, "ecc on");
    chk1(ecc_clear, 1'b1, "ecc clear pulse");
    @(posedge clk);
    chk1(ecc_clear, 1'b0, "ecc clear ends");
    bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
    chk32(rd, 32'h0000_000a, "count cleared");
    wr(`NRS_OFF_CTRL, 32'h0000_0000);
    @(posedge clk);
    chk1(ecc_on, 1'b0, "ecc off");
    $display("test count done");
  endtask

  // codec set lands on the edge where a zero write takes effect
  task automatic t_race();
    wr(`NRS_OFF_STATUS, 32'h0000_0000);
    fork
      wr(`NRS_OFF_STATUS, 32'h0000_0000);
      begin
        repeat (2) @(posedge clk);
        codec_evt <= nrs_evt_t'(8'h08);
        @(posedge clk);
        codec_evt <= nrs_evt_t'(8'h00);
      end
    join
    bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
    chk32(rd, 32'h0000_0001, "set beats clear");
    wr(4'hc, 32'h0000_0000);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk32(rd, 32'h0000_0000, "unmapped read");
    $display("test race done");
  endtask

  // a second reset in mid-run wipes flags, count, enables and the interrupt
  task automatic t_rerst();
    wr(`NRS_OFF_ENABLE, 32'h0000_0017);
    pulse({5'b01001, 3'h2});
    repeat (2) @(posedge clk);
    chk1(irq, 1'b1, "irq before reset");
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    chk1(irq, 1'b0, "irq in reset");
    bus(1'b0, `NRS_OFF_STATUS, 32'h0, rd);
    chk32(rd, 32'h0000_0000, "status after reset");
    bus(1'b0, `NRS_OFF_ENABLE, 32'h0, rd);
    chk32(rd, 32'h0000_0000, "enable after reset");
    $display("test rerst done");
  endtask

  // main sequence
  initial begin
    failures = 0;
    checks = 0;
    srst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    codec_evt = nrs_evt_t'(8'h00);
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_flags();
    t_gate();
    t_count();
    t_race();
    t_rerst();
    summarize();
  end

  // the run needs well under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    summarize();
  end
endmodule
